// file: rtl/asr_pkg.sv
// Shared constants and types of the asynchronous serial receiver
package asr_pkg;
    localparam int ASR_DATA_BITS = 8;
    localparam int ASR_OS_W = 4;
    localparam int ASR_BAUD_CNT_W = 19;
    localparam int ASR_FRAME_W = 10;
    localparam int ASR_NINTH_POS = 8;
    localparam int ASR_FERR_POS = 9;
    localparam int ASR_BUF_DEPTH = 2;
    // Sixteen samples per bit, three votes around the bit centre
    localparam logic [ASR_OS_W-1:0] ASR_VOTE_FIRST = 4'h7;
    localparam logic [ASR_OS_W-1:0] ASR_VOTE_LAST = 4'h9;
    localparam logic [ASR_OS_W-1:0] ASR_BIT_END = 4'hF;
    localparam logic [3:0] ASR_LAST_BIT_8 = 4'h7;
    localparam logic [3:0] ASR_LAST_BIT_9 = 4'h8;
    // Low-speed divisor scales each step by four, both speed bits divide it by four
    localparam int ASR_SCALE_SHIFT = 2;
    localparam logic [ASR_BAUD_CNT_W-1:0] ASR_BAUD_CNT_RST = 19'h00000;
    localparam logic [ASR_FRAME_W-2:0] ASR_SHIFT_RST = 9'h000;
    localparam logic ASR_RX_IDLE_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } asr_state_e;
endpackage

// file: rtl/asr_buf_if.sv
// Valid/ready carrier between the receiver core and its frame buffer
`timescale 1ns/100ps
`default_nettype none
interface asr_buf_if #(parameter int WIDTH = 10);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport producer(output push_valid, output push_data, input push_ready);
    modport buffer(input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
    modport consumer(input pop_valid, input pop_data, output pop_ready);
endinterface
`default_nettype wire

// file: rtl/asr_rx_buffer.sv
// Small shifting frame buffer whose head entry is held in a register
`timescale 1ns/100ps
`default_nettype none
module asr_rx_buffer #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    asr_buf_if.buffer port_if
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0] next_vld;
    logic do_pop;
    logic do_push;

    // A pop in the same cycle frees the last slot, so full never blocks a swap
    assign port_if.push_ready = !vld[DEPTH-1] || port_if.pop_ready;
    assign port_if.pop_valid = vld[0];
    assign port_if.pop_data = mem[0];
    assign do_pop = vld[0] && port_if.pop_ready;
    assign do_push = port_if.push_valid && port_if.push_ready;

    always_comb begin
        logic placed;
        placed = 1'b0;
        next_mem = mem;
        next_vld = vld;
        if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_mem[i] = mem[i+1];
                next_vld[i] = vld[i+1];
            end
            next_vld[DEPTH-1] = 1'b0;
        end
        if (do_push) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!next_vld[i] && !placed) begin
                    next_mem[i] = port_if.push_data;
                    next_vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            vld <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            vld <= next_vld;
            mem <= next_mem;
        end
    end
endmodule
`default_nettype wire

// file: rtl/asr_receiver.sv
// Asynchronous serial receiver: baud divider, oversampled frame shifter, frame buffer
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: Oversample receive pin at sixteen times baud
// R2: Main shifter advances once per bit
// R3: Software loads divisor and speed bits first
// R4: Asynchronous only with port enabled, clocked off
// R5: Frames accepted only while receive enabled
// R6: Nine-bit mode captures and reports ninth bit
// R7: Frame complete sets flag, optional interrupt
// R8: Per-frame error status readable before data
// R9: Data read returns oldest frame's byte
// R10: Dropping receive enable clears pending errors; the code clears only the overrun, and a buffered frame's framing error stays
// R11: Interrupt needs global and peripheral enables
// R12: Priority bit selects interrupt level
// R13: Address detect works with nine-bit mode
// R14: Software checks address byte for match
// R15: Without address detect every frame loads
// R16: Address mode keeps only ninth-bit-one frames
// R17: Flag framing error and buffer overrun
module asr_receiver (
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic RX_I,
    input wire logic [asr_pkg::ASR_DATA_BITS-1:0] BAUD_DIVISOR_HIGH_I,
    input wire logic [asr_pkg::ASR_DATA_BITS-1:0] BAUD_DIVISOR_LOW_I,
    input wire logic HIGH_SPEED_BAUD_SELECT_I,
    input wire logic WIDE_DIVISOR_SELECT_I,
    input wire logic CLOCKED_MODE_SELECT_I,
    input wire logic SERIAL_PORT_ENABLE_I,
    input wire logic CONTINUOUS_RECEIVE_ENABLE_I,
    input wire logic NINE_BIT_RECEIVE_ENABLE_I,
    input wire logic ADDRESS_DETECT_ENABLE_I,
    input wire logic RECEIVE_INT_ENABLE_I,
    input wire logic GLOBAL_INTERRUPT_ENABLE_I,
    input wire logic PERIPHERAL_INTERRUPT_ENABLE_I,
    input wire logic RECEIVE_PRIORITY_SELECT_I,
    input wire logic DATA_READ_I,
    output logic [asr_pkg::ASR_DATA_BITS-1:0] RX_DATA_O,
    output logic NINTH_BIT_O,
    output logic FRAMING_ERROR_O,
    output logic OVERRUN_ERROR_O,
    output logic RECEIVE_COMPLETE_FLAG_O,
    output logic IRQ_HIGH_O,
    output logic IRQ_LOW_O
);
    import asr_pkg::*;

    asr_buf_if #(.WIDTH(ASR_FRAME_W)) buf_if ();

    asr_rx_buffer #(
        .WIDTH(ASR_FRAME_W),
        .DEPTH(ASR_BUF_DEPTH)
    ) u_buffer (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .port_if(buf_if)
    );

    // Baud divider producing the sixteen-times sample enable
    logic [ASR_BAUD_CNT_W-1:0] baud_cnt;
    logic [ASR_BAUD_CNT_W-1:0] next_baud_cnt;
    logic [ASR_BAUD_CNT_W-1:0] reload;
    logic [ASR_BAUD_CNT_W-1:0] div_plus_one;
    logic tick;
    logic active;

    assign active = SERIAL_PORT_ENABLE_I && !CLOCKED_MODE_SELECT_I
                    && CONTINUOUS_RECEIVE_ENABLE_I; // [R4] [R5]

    always_comb begin
        logic [2*ASR_DATA_BITS-1:0] divisor;
        divisor = WIDE_DIVISOR_SELECT_I ? {BAUD_DIVISOR_HIGH_I, BAUD_DIVISOR_LOW_I}
                                        : {{ASR_DATA_BITS{1'b0}}, BAUD_DIVISOR_LOW_I};
        div_plus_one = ASR_BAUD_CNT_W'(divisor) + ASR_BAUD_CNT_W'(1);
        if (HIGH_SPEED_BAUD_SELECT_I && WIDE_DIVISOR_SELECT_I) begin
            // Fastest setting cannot divide below one clock per sample
            reload = div_plus_one >> ASR_SCALE_SHIFT;
            if (reload == '0) begin
                reload = ASR_BAUD_CNT_W'(1);
            end
        end else if (HIGH_SPEED_BAUD_SELECT_I || WIDE_DIVISOR_SELECT_I) begin
            reload = div_plus_one;
        end else begin
            reload = div_plus_one << ASR_SCALE_SHIFT;
        end
        tick = active && (baud_cnt == '0); // [R1]
        if (!active || tick) begin
            next_baud_cnt = reload - ASR_BAUD_CNT_W'(1);
        end else begin
            next_baud_cnt = baud_cnt - ASR_BAUD_CNT_W'(1);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            baud_cnt <= ASR_BAUD_CNT_RST;
        end else begin
            baud_cnt <= next_baud_cnt;
        end
    end

    // Frame shifter
    asr_state_e state;
    asr_state_e next_state;
    logic [ASR_OS_W-1:0] os_cnt;
    logic [ASR_OS_W-1:0] next_os_cnt;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [ASR_FRAME_W-2:0] shifter;
    logic [ASR_FRAME_W-2:0] next_shifter;
    logic [2:0] votes;
    logic [2:0] next_votes;
    logic rx_q;
    logic bit_val;
    logic bit_end;
    logic frame_done;
    logic frame_ninth;
    logic [ASR_DATA_BITS-1:0] frame_byte;
    logic addr_mode;
    logic frame_keep;

    assign bit_val = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
    assign bit_end = tick && (os_cnt == ASR_BIT_END);
    assign frame_done = bit_end && (state == ST_STOP);
    assign addr_mode = ADDRESS_DETECT_ENABLE_I && NINE_BIT_RECEIVE_ENABLE_I; // [R13]

    always_comb begin
        // An 8-bit frame sits one place higher in the right-shifting register
        if (NINE_BIT_RECEIVE_ENABLE_I) begin
            frame_byte = shifter[ASR_DATA_BITS-1:0];
            frame_ninth = shifter[ASR_NINTH_POS]; // [R6]
        end else begin
            frame_byte = shifter[ASR_DATA_BITS:1];
            frame_ninth = 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        next_os_cnt = os_cnt;
        next_bit_cnt = bit_cnt;
        next_shifter = shifter;
        next_votes = votes;
        if (!active) begin
            next_state = ST_IDLE; // [R5]
            next_os_cnt = '0;
        end else if (tick) begin
            if (state == ST_IDLE) begin
                next_os_cnt = '0;
                if (!rx_q) begin
                    next_state = ST_START;
                end
            end else begin
                next_os_cnt = os_cnt + ASR_OS_W'(1); // [R1]
                if (os_cnt >= ASR_VOTE_FIRST && os_cnt <= ASR_VOTE_LAST) begin
                    next_votes = {votes[1:0], rx_q};
                end
                if (os_cnt == ASR_BIT_END) begin
                    unique case (state)
                        ST_START: begin
                            // A glitch shorter than half a bit is not a start
                            next_state = bit_val ? ST_IDLE : ST_DATA;
                            next_bit_cnt = '0;
                        end
                        ST_DATA: begin
                            next_shifter = {bit_val, shifter[ASR_FRAME_W-2:1]}; // [R2]
                            next_bit_cnt = bit_cnt + 4'h1;
                            if (bit_cnt == (NINE_BIT_RECEIVE_ENABLE_I ? ASR_LAST_BIT_9
                                                                      : ASR_LAST_BIT_8)) begin
                                next_state = ST_STOP; // [R6]
                            end
                        end
                        ST_STOP: begin
                            next_state = ST_IDLE;
                        end
                        ST_IDLE: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            state <= ST_IDLE;
            os_cnt <= '0;
            bit_cnt <= '0;
            shifter <= ASR_SHIFT_RST;
            votes <= '0;
            rx_q <= ASR_RX_IDLE_LEVEL;
        end else begin
            state <= next_state;
            os_cnt <= next_os_cnt;
            bit_cnt <= next_bit_cnt;
            shifter <= next_shifter;
            votes <= next_votes;
            rx_q <= RX_I;
        end
    end

    // Loading, error status and interrupt request
    logic overrun;
    logic next_overrun;
    logic next_irq_high;
    logic next_irq_low;

    // While an overrun stands no further frame is loaded
    assign frame_keep = frame_done && (!addr_mode || frame_ninth) && !overrun; // [R15] [R16]
    assign buf_if.push_valid = frame_keep && buf_if.push_ready;
    assign buf_if.push_data = {!bit_val, frame_ninth, frame_byte}; // [R17] [R8]
    assign buf_if.pop_ready = DATA_READ_I; // [R9]

    always_comb begin
        next_overrun = overrun;
        if (frame_keep && !buf_if.push_ready) begin
            next_overrun = 1'b1; // [R17]
        end else if (!CONTINUOUS_RECEIVE_ENABLE_I) begin
            next_overrun = 1'b0; // [R10]
        end
        next_irq_high = buf_if.pop_valid && RECEIVE_INT_ENABLE_I && GLOBAL_INTERRUPT_ENABLE_I
                        && PERIPHERAL_INTERRUPT_ENABLE_I && RECEIVE_PRIORITY_SELECT_I; // [R11]
        next_irq_low = buf_if.pop_valid && RECEIVE_INT_ENABLE_I && GLOBAL_INTERRUPT_ENABLE_I
                       && PERIPHERAL_INTERRUPT_ENABLE_I && !RECEIVE_PRIORITY_SELECT_I; // [R12]
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            overrun <= 1'b0;
            IRQ_HIGH_O <= 1'b0;
            IRQ_LOW_O <= 1'b0;
        end else begin
            overrun <= next_overrun;
            IRQ_HIGH_O <= next_irq_high; // [R7]
            IRQ_LOW_O <= next_irq_low;
        end
    end

    assign OVERRUN_ERROR_O = overrun;
    assign RECEIVE_COMPLETE_FLAG_O = buf_if.pop_valid; // [R7]
    assign RX_DATA_O = buf_if.pop_data[ASR_DATA_BITS-1:0]; // [R9]
    assign NINTH_BIT_O = buf_if.pop_data[ASR_NINTH_POS]; // [R6]
    assign FRAMING_ERROR_O = buf_if.pop_data[ASR_FERR_POS]; // [R8]

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SRST_I);

    a_off_goes_idle: assert property (!active |=> state == ST_IDLE) // [R4] [R5]
        else $error("receiver not idle while disabled");

    a_sample_step: assert property (tick && state != ST_IDLE && active // [R1]
                                     |=> os_cnt == $past(os_cnt) + ASR_OS_W'(1))
        else $error("oversample counter did not advance");

    a_start_on_low: assert property ($rose(state == ST_START) |-> !$past(rx_q)) // [R1]
        else $error("start entered without low line");

    a_frame_loads: assert property (frame_done && !addr_mode && !overrun // [R7] [R15]
                                    && buf_if.push_ready && !DATA_READ_I
                                    |=> RECEIVE_COMPLETE_FLAG_O)
        else $error("completed frame not flagged");

    a_addr_discard: assert property (frame_done && addr_mode && !frame_ninth // [R16]
                                     |-> !buf_if.push_valid)
        else $error("address mode loaded ninth-bit-zero frame");

    // Software may drop receive enable right after an overrun, which clears it at once
    a_overrun_set: assert property ((frame_keep && !buf_if.push_ready) // [R17]
                                    ##1 CONTINUOUS_RECEIVE_ENABLE_I
                                    |-> OVERRUN_ERROR_O [*2])
        else $error("overrun not flagged");

    a_error_clear: assert property (!CONTINUOUS_RECEIVE_ENABLE_I // [R10]
                                    && !$past(CONTINUOUS_RECEIVE_ENABLE_I)
                                    |-> !OVERRUN_ERROR_O)
        else $error("overrun not cleared by receive disable");

    a_irq_gated: assert property (IRQ_HIGH_O || IRQ_LOW_O // [R11]
                                  |-> $past(GLOBAL_INTERRUPT_ENABLE_I)
                                  && $past(PERIPHERAL_INTERRUPT_ENABLE_I)
                                  && $past(RECEIVE_INT_ENABLE_I)
                                  && $past(RECEIVE_COMPLETE_FLAG_O))
        else $error("interrupt without enables");

    a_irq_level: assert property (IRQ_HIGH_O // [R12]
                                  |-> !IRQ_LOW_O && $past(RECEIVE_PRIORITY_SELECT_I))
        else $error("interrupt on wrong level");

    a_eight_bit_ninth: assert property (buf_if.push_valid && !NINE_BIT_RECEIVE_ENABLE_I // [R6]
                                        |-> !buf_if.push_data[ASR_NINTH_POS])
        else $error("ninth bit set in eight-bit mode");

    a_framing_flag: assert property (buf_if.push_valid // [R17]
                                     |-> buf_if.push_data[ASR_FERR_POS] == !bit_val)
        else $error("framing error does not follow stop bit");

    c_frame_loaded: cover property (buf_if.push_valid && !buf_if.push_data[ASR_FERR_POS]);
    c_addr_dropped: cover property (frame_done && addr_mode && !frame_ninth);
    c_overrun: cover property ($rose(OVERRUN_ERROR_O));
    c_buffer_full: cover property (buf_if.pop_valid && !buf_if.push_ready);
    c_start_rejected: cover property (state == ST_START && bit_end && bit_val);
endmodule
`default_nettype wire

// file: tb/asr_serial_tx.sv
// Behavioural remote transmitter that drives the receiver's serial line
`timescale 1ns/100ps
`default_nettype none
module asr_serial_tx #(
    parameter int BIT_CYCLES = 64
) (
    input wire logic clk_i,
    output logic line_o
);
    // Idle level is high, as between frames on a real line
    initial begin
        line_o = 1'b1;
    end

    task automatic hold_bit(input logic level);
        line_o = level;
        repeat (BIT_CYCLES) @(posedge clk_i);
        #1;
    endtask

    // Low pulse shorter than half a bit, which must not pass for a start bit
    task automatic glitch(input int cycles);
        @(posedge clk_i);
        #1;
        line_o = 1'b0;
        repeat (cycles) @(posedge clk_i);
        #1;
        line_o = 1'b1;
    endtask

    // LSB first; one idle bit after the stop bit lets the receiver settle
    task automatic send(input logic [8:0] data, input logic nine, input logic stop_level);
        int n;
        n = nine ? 9 : 8;
        @(posedge clk_i);
        #1;
        hold_bit(1'b0);
        for (int i = 0; i < n; i++) begin
            hold_bit(data[i]);
        end
        hold_bit(stop_level);
        hold_bit(1'b1);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_asr_receiver.sv
// Self-checking testbench of the asynchronous serial receiver
`timescale 1ns/100ps
`default_nettype none
module tb_asr_receiver;
    import asr_pkg::*;
    logic clk, srst, hs, wide, clocked, serial_port_enable, continuous_receive_enable, nine, address_detect_enable, rie, global_interrupt_enable, peripheral_interrupt_enable, prio, rd;
    logic [7:0] div_high, div_low;
    wire rx;
    logic [7:0] rx_data;
    logic ninth, ferr, oerr, flag, irq_high, irq_low;
    int fail_count = 0;
    int n_tests = 0;
    // Every setting gives four cycles per sample, sixty-four per bit;
    // the high byte must be ignored unless the wide divisor is selected
    logic cfg_hs [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] cfg_high [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
    logic cfg_wide [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] cfg_low [4] = '{8'h00, 8'h03, 8'h03, 8'h0F};

    asr_serial_tx #(.BIT_CYCLES(64)) asr_serial_tx_i (.clk_i(clk), .line_o(rx));

    asr_receiver asr_receiver_i (
        .REF_CLK_I(clk), .SRST_I(srst), .RX_I(rx),
        .BAUD_DIVISOR_HIGH_I(div_high), .BAUD_DIVISOR_LOW_I(div_low),
        .HIGH_SPEED_BAUD_SELECT_I(hs), .WIDE_DIVISOR_SELECT_I(wide),
        .CLOCKED_MODE_SELECT_I(clocked), .SERIAL_PORT_ENABLE_I(serial_port_enable),
        .CONTINUOUS_RECEIVE_ENABLE_I(continuous_receive_enable), .NINE_BIT_RECEIVE_ENABLE_I(nine),
        .ADDRESS_DETECT_ENABLE_I(address_detect_enable), .RECEIVE_INT_ENABLE_I(rie),
        .GLOBAL_INTERRUPT_ENABLE_I(global_interrupt_enable), .PERIPHERAL_INTERRUPT_ENABLE_I(peripheral_interrupt_enable),
        .RECEIVE_PRIORITY_SELECT_I(prio), .DATA_READ_I(rd),
        .RX_DATA_O(rx_data), .NINTH_BIT_O(ninth), .FRAMING_ERROR_O(ferr),
        .OVERRUN_ERROR_O(oerr), .RECEIVE_COMPLETE_FLAG_O(flag),
        .IRQ_HIGH_O(irq_high), .IRQ_LOW_O(irq_low)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait; a frame that never lands closes the run
    task automatic wait_flag();
        int i;
        for (i = 0; i < 300 && flag !== 1'b1; i++) begin
            tick(1);
        end
        if (flag !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: no frame arrived", $time);
            end_sim();
        end
    endtask

    task automatic pop();
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(2);
    endtask

    task automatic send(input logic [8:0] data, input logic stop_level);
        asr_serial_tx_i.send(data, nine, stop_level);
    endtask

    initial begin
        {hs, wide, clocked, serial_port_enable, continuous_receive_enable, nine, address_detect_enable, rie, global_interrupt_enable, peripheral_interrupt_enable, prio, rd} = 12'h000;
        div_high = 8'h00;
        div_low = 8'h00;
        srst = 1'b1;
        tick(16);
        srst = 1'b0;
        check({rx_data, ninth}, 9'h000);
        check({4'h0, ferr, oerr, flag, irq_high, irq_low}, 9'h000);
        serial_port_enable = 1'b1;
        continuous_receive_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            hs = cfg_hs[k];
            wide = cfg_wide[k];
            div_low = cfg_low[k];
            div_high = cfg_high[k];
            send(9'h0A5 + 9'(k), 1'b1);
            wait_flag();
            check({1'b0, rx_data}, 9'h0A5 + 9'(k));
            check({7'h00, ninth, ferr}, 9'h000);
            pop();
            check({8'h00, flag}, 9'h000);
        end
        hs = 1'b0;
        wide = 1'b0;
        div_low = 8'h00;
        send(9'h03C, 1'b1);
        wait_flag();
        rie = 1'b1;
        global_interrupt_enable = 1'b1;
        prio = 1'b1;
        tick(2);
        check({7'h00, irq_high, irq_low}, 9'h000);
        global_interrupt_enable = 1'b0;
        peripheral_interrupt_enable = 1'b1;
        tick(2);
        check({7'h00, irq_high, irq_low}, 9'h000);
        global_interrupt_enable = 1'b1;
        tick(2);
        check({7'h00, irq_high, irq_low}, 9'h002);
        prio = 1'b0;
        tick(2);
        check({7'h00, irq_high, irq_low}, 9'h001);
        pop();
        tick(1);
        check({6'h00, flag, irq_high, irq_low}, 9'h000);
        nine = 1'b1;
        send(9'h15A, 1'b1);
        wait_flag();
        check({ninth, rx_data}, 9'h15A);
        pop();
        address_detect_enable = 1'b1;
        send(9'h011, 1'b1);
        tick(20);
        check({8'h00, flag}, 9'h000);
        send(9'h122, 1'b1);
        wait_flag();
        check({ninth, rx_data}, 9'h122);
        pop();
        address_detect_enable = 1'b0;
        send(9'h033, 1'b1);
        wait_flag();
        check({ninth, rx_data}, 9'h033);
        pop();
        nine = 1'b0;
        send(9'h077, 1'b0);
        wait_flag();
        check({ferr, rx_data}, 9'h177);
        pop();
        // Third frame lands on a full buffer and must be lost
        send(9'h001, 1'b1);
        send(9'h002, 1'b1);
        send(9'h003, 1'b1);
        check({oerr, rx_data}, 9'h101);
        pop();
        check({1'b0, rx_data}, 9'h002);
        pop();
        check({8'h00, flag}, 9'h000);
        continuous_receive_enable = 1'b0;
        tick(2);
        check({8'h00, oerr}, 9'h000);
        send(9'h044, 1'b1);
        tick(20);
        check({8'h00, flag}, 9'h000);
        continuous_receive_enable = 1'b1;
        serial_port_enable = 1'b0;
        send(9'h045, 1'b1);
        tick(20);
        check({8'h00, flag}, 9'h000);
        serial_port_enable = 1'b1;
        clocked = 1'b1;
        send(9'h046, 1'b1);
        tick(20);
        check({8'h00, flag}, 9'h000);
        clocked = 1'b0;
        asr_serial_tx_i.glitch(16);
        tick(100);
        check({8'h00, flag}, 9'h000);
        send(9'h055, 1'b1);
        wait_flag();
        check({1'b0, rx_data}, 9'h055);
        pop();
        end_sim();
    end
endmodule
`default_nettype wire
